//--- logic/rxaf_pkg.sv
/*
  Package for the receive acceptance filter and buffer control block.
  Holds register offsets, field positions, reset values, buffer sizes and
  the packed structs that carry frame classification and byte streams.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package rxaf_pkg;

  // ==========================================================
  // Register map (offsets are byte addresses of this block)
  localparam logic [7:0] REG_RX_CONTROL = 8'h00;
  localparam logic [7:0] REG_RX_STATUS = 8'h04;

  // ==========================================================
  // Receive control field positions
  localparam int BIT_BCAST_ACCEPT = 15;
  localparam int BIT_RX_BUFFER_SIZE_SEL_LO = 16;
  localparam int BIT_VLAN_FILTER = 18;
  localparam int BIT_CANON_CHECK = 19;
  localparam int BIT_CANON_VALUE = 20;
  localparam int BIT_DISCARD_PAUSE = 22;
  localparam int BIT_PASS_CTRL = 23;
  localparam int BIT_SIZE_EXTEND = 25;
  localparam int BIT_STRIP_FCS = 26;

  // Bits software may hold; reserved 21, 24, 31:27 and 14:0 are zero
  localparam logic [31:0] CTRL_WRITABLE_MASK = 32'h06df_8000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // ==========================================================
  // Buffer size encodings in bytes
  localparam logic [14:0] BUF_BASE_2048 = 15'h0800;
  localparam logic [14:0] BUF_BASE_1024 = 15'h0400;
  localparam logic [14:0] BUF_BASE_512 = 15'h0200;
  localparam logic [14:0] BUF_BASE_256 = 15'h0100;
  localparam int BUF_EXT_SHIFT = 4;
  localparam int FCS_BYTES = 4;

  // ==========================================================
  // Frame classification delivered with the frame start
  typedef struct packed {
    logic is_broadcast;
    logic addr_match;
    logic is_vlan;
    logic vlan_table_hit;
    logic vlan_cfi;
    logic is_pause;
    logic to_station0;
    logic is_mac_ctrl;
    logic ctrl_dest_ok;
  } rxaf_class_t;

  // One received byte with its frame delimiters
  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } rxaf_byte_t;

  // Decision for a finished frame
  typedef struct packed {
    logic valid;
    logic accept;
    logic [15:0] length;
  } rxaf_verdict_t;

endpackage

`default_nettype wire

//--- logic/rxaf_fcs_delay.sv
/*
  Four-byte delay line used to hold back the trailing frame checksum.
  Emits each byte once four newer bytes of the same frame are seen, so
  the last four bytes can be dropped at end of frame when stripping.
  Assumes a byte stream with no gaps inside a frame is not required.
*/
`timescale 1ns/1ps
`default_nettype none

module rxaf_fcs_delay #(
  parameter int DEPTH = rxaf_pkg::FCS_BYTES
) (
  input wire logic sys_clk,
  input wire logic rst_n_sync,
  input wire logic strip,
  input wire rxaf_pkg::rxaf_byte_t in_byte,
  output rxaf_pkg::rxaf_byte_t out_byte
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] data;
    logic [2:0] fill;
    logic lead;
    rxaf_pkg::rxaf_byte_t out;
  } rxaf_dly_state_t;

  rxaf_dly_state_t state_r;
  rxaf_dly_state_t state_nxt;

  // ==========================================================
  // Shift and release logic
  always_comb begin
    state_nxt = state_r;
    state_nxt.out = '0;
    if (in_byte.valid) begin
      if (!strip) begin
        // Pass-through when checksum is kept
        state_nxt.out = in_byte;
      end else begin
        // A new frame refills the line; its first release carries sof
        if (in_byte.sof) begin
          state_nxt.fill = 3'h0;
          state_nxt.lead = 1'b1;
        end
        if (state_nxt.fill == 3'(DEPTH)) begin
          state_nxt.out.valid = 1'b1;
          state_nxt.out.sof = state_nxt.lead;
          state_nxt.out.data = state_r.data[DEPTH-1];
          state_nxt.lead = 1'b0;
        end else begin
          state_nxt.fill = state_nxt.fill + 3'h1;
        end
        state_nxt.data = {state_r.data[DEPTH-2:0], in_byte.data};
        // The final four bytes stay behind and are overwritten next frame
        if (in_byte.eof) begin
          state_nxt.out.eof = state_nxt.out.valid;
          state_nxt.fill = 3'h0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign out_byte = state_r.out;

endmodule

`default_nettype wire

//--- logic/rxaf_top.sv
/*
  Receive acceptance filter and buffer size control.
  Holds the receive control register, classifies each frame against it,
  strips the checksum if asked and reports buffer size and verdict.
  Assumes the MAC front end supplies a byte stream and a per-frame
  classification valid with the first byte; DMA consumes the verdict.
*/
`timescale 1ns/1ps
`default_nettype none

module rxaf_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire rxaf_pkg::rxaf_byte_t rx_in,
  input wire rxaf_pkg::rxaf_class_t rx_class,
  output rxaf_pkg::rxaf_byte_t rx_out,
  output rxaf_pkg::rxaf_verdict_t verdict,
  output logic [14:0] rx_buf_bytes
);

  // ==========================================================
  // Reset release: asynchronous assert, synchronous release
  logic [1:0] rst_sync_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  logic rst_n_sync;
  assign rst_n_sync = rst_sync_r[1];

  // ==========================================================
  // Block state
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] active;
    logic in_frame;
    logic accept;
    logic [15:0] count;
    logic [15:0] accepted;
    logic [15:0] dropped;
    logic [31:0] rdata;
    rxaf_pkg::rxaf_verdict_t verdict;
    logic [14:0] buf_bytes;
  } rxaf_state_t;

  rxaf_state_t state_r;
  rxaf_state_t state_nxt;

  rxaf_pkg::rxaf_byte_t dly_out;
  logic frame_ok;
  logic strip_now;

  // The first byte of a frame must already see the settings it latches
  assign strip_now = (rx_in.valid && rx_in.sof) ? state_r.ctrl[rxaf_pkg::BIT_STRIP_FCS]
                                                : state_r.active[rxaf_pkg::BIT_STRIP_FCS];

  // Checksum delay line; strip follows the latched frame setting
  rxaf_fcs_delay #(
    .DEPTH(rxaf_pkg::FCS_BYTES)
  ) u_fcs_delay (
    .sys_clk(sys_clk),
    .rst_n_sync(rst_n_sync),
    .strip(strip_now),
    .in_byte(rx_in),
    .out_byte(dly_out)
  );

  // ==========================================================
  // Buffer size decode from a control word
  function automatic logic [14:0] rxaf_buf_size(input logic [31:0] c);
    logic [14:0] base;
    base = rxaf_pkg::BUF_BASE_2048;
    case (c[rxaf_pkg::BIT_RX_BUFFER_SIZE_SEL_LO +: 2])
      2'h0: base = rxaf_pkg::BUF_BASE_2048;
      2'h1: base = rxaf_pkg::BUF_BASE_1024;
      2'h2: base = rxaf_pkg::BUF_BASE_512;
      2'h3: base = rxaf_pkg::BUF_BASE_256;
      default: base = rxaf_pkg::BUF_BASE_2048;
    endcase
    // Reserved 00 with extension would be 32 KiB, which does not fit;
    // software must not use it, so it reports zero
    if (c[rxaf_pkg::BIT_SIZE_EXTEND]) begin
      if (c[rxaf_pkg::BIT_RX_BUFFER_SIZE_SEL_LO +: 2] == 2'h0) begin
        base = 15'h0000;
      end else begin
        base = base << rxaf_pkg::BUF_EXT_SHIFT;
      end
    end
    return base;
  endfunction

  // ==========================================================
  // Frame acceptance from the latched settings and classification
  function automatic logic rxaf_accept(input logic [31:0] c,
                                       input rxaf_pkg::rxaf_class_t k);
    logic ok;
    ok = k.addr_match;
    if (k.is_broadcast && c[rxaf_pkg::BIT_BCAST_ACCEPT]) begin
      ok = 1'b1;
    end
    if (k.is_vlan && c[rxaf_pkg::BIT_VLAN_FILTER] && !k.vlan_table_hit) begin
      ok = 1'b0;
    end
    if (k.is_vlan && c[rxaf_pkg::BIT_CANON_CHECK]) begin
      if (k.vlan_cfi != c[rxaf_pkg::BIT_CANON_VALUE]) begin
        ok = 1'b0;
      end
    end
    if (k.is_pause && k.to_station0 && c[rxaf_pkg::BIT_DISCARD_PAUSE]) begin
      ok = 1'b0;
    end
    if (k.is_mac_ctrl && !k.is_pause) begin
      ok = ok && k.ctrl_dest_ok && c[rxaf_pkg::BIT_PASS_CTRL];
    end
    return ok;
  endfunction

  assign frame_ok = rxaf_accept(state_r.ctrl, rx_class);

  // ==========================================================
  // Register access, frame tracking and verdict
  always_comb begin
    state_nxt = state_r;
    state_nxt.rdata = 32'h0000_0000;
    state_nxt.verdict = '0;

    if (reg_wr && reg_addr == rxaf_pkg::REG_RX_CONTROL) begin
      state_nxt.ctrl = reg_wdata & rxaf_pkg::CTRL_WRITABLE_MASK;
    end
    if (reg_rd) begin
      case (reg_addr)
        rxaf_pkg::REG_RX_CONTROL: state_nxt.rdata = state_r.ctrl;
        rxaf_pkg::REG_RX_STATUS: state_nxt.rdata = {state_r.dropped,
                                                     state_r.accepted};
        default: state_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Settings take effect only at a frame boundary
    if (rx_in.valid && rx_in.sof) begin
      state_nxt.active = state_r.ctrl;
      state_nxt.accept = frame_ok;
      state_nxt.in_frame = 1'b1;
      state_nxt.buf_bytes = rxaf_buf_size(state_r.ctrl);
    end

    // Count delivered bytes; stripped checksum never reaches the count
    if (dly_out.valid) begin
      state_nxt.count = dly_out.sof ? 16'h0001 : state_r.count + 16'h0001;
      if (dly_out.eof) begin
        state_nxt.verdict.valid = 1'b1;
        state_nxt.verdict.accept = state_r.accept;
        state_nxt.verdict.length = state_nxt.count;
        state_nxt.in_frame = 1'b0;
        if (state_r.accept) begin
          state_nxt.accepted = state_r.accepted + 16'h0001;
        end else begin
          state_nxt.dropped = state_r.dropped + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_r <= '0;
      state_r.ctrl <= rxaf_pkg::CTRL_RESET;
      state_r.active <= rxaf_pkg::CTRL_RESET;
      state_r.buf_bytes <= rxaf_pkg::BUF_BASE_2048;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Data to DMA: gated by the frame verdict, one cycle behind the delay line
  rxaf_pkg::rxaf_byte_t out_r;

  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      out_r <= '0;
    end else begin
      out_r <= state_r.accept ? dly_out : '0;
    end
  end

  assign rx_out = out_r;
  assign reg_rdata = state_r.rdata;
  assign verdict = state_r.verdict;
  assign rx_buf_bytes = state_r.buf_bytes;

endmodule

`default_nettype wire

//--- sim/rxaf_phy_model.sv
/*
  PHY-side frame source for the receive filter bench.
  Assumes the bench calls send_frame and runs one frame at a time.
*/
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Frame source
module rxaf_phy_model (
  output rxaf_pkg::rxaf_byte_t rx_in,
  output rxaf_pkg::rxaf_class_t rx_class,
  input wire logic sys_clk
);
  initial begin
    rx_in = '0;
    rx_class = '0;
  end
  // Class is only valid with sof; other cycles show its inverse so stale reads fail
  task automatic send_frame(input int n, input rxaf_pkg::rxaf_class_t k);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rx_in <= '{1'b1, i == 0, i == n - 1, 8'(i) ^ 8'h5a};
      rx_class <= (i == 0) ? k : ~k;
    end
    @(posedge sys_clk);
    rx_in <= '{1'b0, 1'b0, 1'b0, ~rx_in.data};
  endtask
endmodule
`default_nettype wire

//--- sim/rxaf_properties.sv
/*
  Port-level assertions for the receive filter block.
  Assumes it is bound to rxaf_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module rxaf_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire rxaf_pkg::rxaf_byte_t rx_in,
  input wire rxaf_pkg::rxaf_byte_t rx_out,
  input wire rxaf_pkg::rxaf_verdict_t verdict,
  input wire logic [14:0] rx_buf_bytes
);
  logic sof_in;
  logic ctl;
  // Size may only move just after a frame start, never mid-frame
  assign sof_in = rx_in.valid & rx_in.sof;
  assign ctl = reg_addr == rxaf_pkg::REG_RX_CONTROL;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not idle");
  a_rsvd_zero: assert property ($past(reg_rd) && $past(ctl) |->
    (reg_rdata & ~rxaf_pkg::CTRL_WRITABLE_MASK) == 32'h0) else $error("reserved bit set");
  a_ctrl_readback: assert property (reg_wr && ctl ##1 reg_rd && !reg_wr && ctl |=>
    reg_rdata == ($past(reg_wdata, 2) & rxaf_pkg::CTRL_WRITABLE_MASK)) else $error("readback");
  a_buf_legal: assert property (rx_buf_bytes inside {15'h0800, 15'h0400, 15'h0200,
    15'h0100, 15'h4000, 15'h2000, 15'h1000, 15'h0000}) else $error("bad buffer size");
  a_buf_hold: assert property (!$past(sof_in) && !$past(sof_in, 2) |->
    $stable(rx_buf_bytes)) else $error("size moved mid-frame");
  a_out_cause: assert property (rx_out.valid |-> $past(rx_in.valid, 2))
    else $error("output without input");
  a_verdict_at_end: assert property (verdict.valid |-> $past(rx_in.valid && rx_in.eof, 2))
    else $error("verdict not at frame end");
  a_reject_quiet: assert property (verdict.valid && !verdict.accept |->
    !rx_out.valid ##1 !rx_out.valid) else $error("rejected frame output");
  c_accept: cover property (verdict.valid && verdict.accept);
  c_reject: cover property (verdict.valid && !verdict.accept);
  c_read: cover property ($past(reg_rd) && reg_rdata != 32'h0);
endmodule
bind rxaf_top rxaf_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_in(rx_in), .rx_out(rx_out), .verdict(verdict), .rx_buf_bytes(rx_buf_bytes));
`default_nettype wire

//--- sim/rxaf_top_tb.sv
/*
  Self-checking bench for the receive filter block.
  Assumes the PHY model and the bound checker compile beside it.
*/
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench
module rx_accept_filter_and_buffer_ctrl_tb_top;
  logic sys_clk, rst_n, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, raw, d;
  rxaf_pkg::rxaf_byte_t rx_in, rx_out;
  rxaf_pkg::rxaf_class_t k, rx_class;
  rxaf_pkg::rxaf_verdict_t verdict;
  logic [14:0] rx_buf_bytes, v_buf;
  logic [15:0] v_len;
  logic v_acc, a;
  int n_mismatch, n_compared, n_verdict, n_out, out_idx, nv, n, t, cyc, n_acc, n_drop;
  rxaf_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_in(rx_in),
    .rx_class(rx_class), .rx_out(rx_out), .verdict(verdict), .rx_buf_bytes(rx_buf_bytes));
  rxaf_phy_model phy (.rx_in(rx_in), .rx_class(rx_class), .sys_clk(sys_clk));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, wd};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, sampled mid-cycle
  task automatic reg_read(input logic [7:0] ad, output logic [31:0] rd);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, ad};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rd = reg_rdata;
  endtask
  // Write then read back with no idle cycle between the strobes
  task automatic reg_write_read(input logic [7:0] ad, input logic [31:0] wd,
                                output logic [31:0] rd);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, wd};
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'b01;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rd = reg_rdata;
  endtask
  // Expected verdict: pause and control frames first, then address, VLAN, CANONICAL_BIT_VALUE
  function automatic logic exp_acc(logic [31:0] c, rxaf_pkg::rxaf_class_t x);
    logic r;
    if (x.is_pause) return !c[22];
    if (x.is_mac_ctrl) return c[23] & x.addr_match & x.ctrl_dest_ok;
    r = x.addr_match | (x.is_broadcast & c[15]);
    if (x.is_vlan & c[18] & !x.vlan_table_hit) r = 1'b0;
    if (x.is_vlan & c[19] & (x.vlan_cfi != c[20])) r = 1'b0;
    return r;
  endfunction
  // Clock, timeout and output monitor
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 12000) begin
      n_mismatch++;
      tally_and_finish();
    end
    if (verdict.valid) begin
      n_verdict++;
      {v_acc, v_len, v_buf} = {verdict.accept, verdict.length, rx_buf_bytes};
    end
    if (rx_out.valid) begin
      check("rx_out.data", rx_out.data, 8'(out_idx) ^ 8'h5a);
      out_idx++;
      n_out++;
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, k} = '0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    void'($urandom(37031));
    reg_read(rxaf_pkg::REG_RX_CONTROL, d);
    check("ctrl reset", d, rxaf_pkg::CTRL_RESET);
    reg_read(8'h10, d);
    check("unmapped", d, 32'h0);
    for (int i = 0; i < 64; i++) begin
      raw = $urandom;
      if (i < 8) {raw[25], raw[17:16]} = 3'(i);
      if (raw[25] && raw[17:16] == 2'b00) raw[17:16] = 2'b01;
      t = i % 4;
      k = rxaf_pkg::rxaf_class_t'($urandom);
      {k.is_vlan, k.is_pause, k.is_mac_ctrl, k.to_station0} = {t == 1, t == 2, t == 3, t == 2};
      k.is_broadcast &= t < 2;
      k.addr_match |= t == 2;
      n = 5 + $urandom % 12;
      reg_write_read(rxaf_pkg::REG_RX_CONTROL, raw, d);
      check("control", d, raw & rxaf_pkg::CTRL_WRITABLE_MASK);
      {nv, n_out, out_idx} = {n_verdict, 32'd0, 32'd0};
      // Flipping settings mid-frame must not touch the frame in flight
      if (i % 8 == 7) fork
        phy.send_frame(n, k);
        begin
          repeat (2) @(posedge sys_clk);
          reg_write(rxaf_pkg::REG_RX_CONTROL, raw ^ 32'h04c0_8000);
        end
      join
      else phy.send_frame(n, k);
      for (int w = 0; w < 50 && n_verdict == nv; w++) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      a = exp_acc(raw, k);
      if (a) n_acc++;
      else n_drop++;
      check("verdicts", n_verdict, nv + 1);
      check("accept", v_acc, a);
      check("buf_bytes", v_buf, (15'h0800 >> raw[17:16]) << (raw[25] ? 4 : 0));
      check("out_count", n_out, a ? (raw[26] ? n - 4 : n) : 0);
      if (a) check("length", v_len, raw[26] ? n - 4 : n);
    end
    reg_read(rxaf_pkg::REG_RX_STATUS, d);
    check("status", d, {16'(n_drop), 16'(n_acc)});
    tally_and_finish();
  end
endmodule
`default_nettype wire
